/* hdl/fpd_pkg.sv */
// Package for the external flash programming mode decoder
package fpd_pkg;

  // ==========================================================
  // Select pin patterns {p26, p27, p36, p37, p25}
  // ==========================================================
  localparam logic [4:0] SEL_WR_LOWER  = 5'h0E;
  localparam logic [4:0] SEL_WR_UPPER  = 5'h0F;
  localparam logic [4:0] SEL_LOCK1     = 5'h1F;
  localparam logic [4:0] SEL_LOCK2     = 5'h19;
  localparam logic [4:0] SEL_LOCK3     = 5'h15;
  localparam logic [4:0] SEL_ERASE     = 5'h11;
  localparam logic [4:0] SEL_SIG       = 5'h00;
  // Read patterns ignore port2_bit7, which toggles
  localparam logic [4:0] SEL_RD_MASK   = 5'h17;
  localparam logic [4:0] SEL_RD_LOWER  = 5'h06;
  localparam logic [4:0] SEL_RD_UPPER  = 5'h07;

  // Lock bit positions
  localparam int LOCK1_POS = 0;
  localparam int LOCK2_POS = 1;
  localparam int LOCK3_POS = 2;
  localparam logic [2:0] LOCK_RST = 3'h0;

  // Least clock while writing flash
  localparam int MIN_WRITE_CLK_MHZ = 4;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [3:0] {
    FPD_OP_NONE,
    FPD_OP_WR_LOWER,
    FPD_OP_RD_LOWER,
    FPD_OP_WR_UPPER,
    FPD_OP_RD_UPPER,
    FPD_OP_LOCK1,
    FPD_OP_LOCK2,
    FPD_OP_LOCK3,
    FPD_OP_ERASE,
    FPD_OP_SIG
  } fpd_op_e;

  typedef struct packed {
    logic rst_pin;
    logic program_store_enable_n;
    logic addr_latch_program_strobe;
    logic external_access_vpp;
    logic port2_bit6;
    logic port2_bit7;
    logic port3_bit6;
    logic port3_bit7;
    logic port2_bit5;
  } fpd_pins_s;

  typedef struct packed {
    logic wr_lower;
    logic wr_upper;
    logic mass_erase;
    logic rd_lower;
    logic rd_upper;
    logic rd_sig;
  } fpd_cmd_s;

endpackage : fpd_pkg

/* hdl/fpd_decode.sv */
// External flash programming mode decoder
`timescale 1ns/1ps
module fpd_decode
  import fpd_pkg::*;
(
  input  wire logic      mclk,      // 250 MHz clock
  input  wire logic      rst,       // Async reset, active high
  input  wire fpd_pins_s pins,      // Programming pins, synchronous
  output fpd_cmd_s       cmd,       // One-cycle operation pulses, signature a level
  output logic [2:0]     lock_bits, // Sticky lock bits
  output fpd_op_e        mode       // Decoded mode, registered
);

  // ==========================================================
  // Decode
  // ==========================================================
  logic      [4:0] sel;
  logic            prog_en;
  logic            strobe_rise;
  logic            toggle;
  fpd_op_e         op;
  fpd_pins_s       pins_ff;
  fpd_cmd_s        nxt_cmd;
  logic      [2:0] nxt_lock;

  // Select pattern
  assign sel = {pins.port2_bit6, pins.port2_bit7, pins.port3_bit6,
                pins.port3_bit7, pins.port2_bit5};

  // Programming mode gate
  assign prog_en = pins.rst_pin & ~pins.program_store_enable_n
                 & pins.external_access_vpp;

  // Strobe pulse completes on its rising edge (low phase held first)
  assign strobe_rise = pins.addr_latch_program_strobe
                     & ~pins_ff.addr_latch_program_strobe;

  // Read strobe: port2_bit7 moved since the last sample
  assign toggle = pins.port2_bit7 ^ pins_ff.port2_bit7;

  // ==========================================================
  // Pattern matches
  // ==========================================================
  // Write family matches the full five-pin pattern; one stray pin can
  // alias onto a neighbouring operation, since SEL_WR_LOWER and SEL_WR_UPPER differ only in port2_bit5
  wire hit_wr_lower = (sel == SEL_WR_LOWER);
  wire hit_wr_upper = (sel == SEL_WR_UPPER);
  wire hit_lock1    = (sel == SEL_LOCK1);
  wire hit_lock2    = (sel == SEL_LOCK2);
  wire hit_lock3    = (sel == SEL_LOCK3);
  wire hit_erase    = (sel == SEL_ERASE);
  wire hit_sig      = (sel == SEL_SIG);

  // Read family ignores port2_bit7, which the programmer toggles
  wire hit_rd_lower = ((sel & SEL_RD_MASK) == SEL_RD_LOWER);
  wire hit_rd_upper = ((sel & SEL_RD_MASK) == SEL_RD_UPPER);

  // ==========================================================
  // Strobe qualifiers
  // ==========================================================
  // Strobe level now, and strobe held high over two samples
  wire stb_now = pins.addr_latch_program_strobe;
  wire st_hi   = stb_now & pins_ff.addr_latch_program_strobe;

  // Write family fires once per strobe pulse, only while gated
  wire wr_fire = prog_en & strobe_rise;

  // Read family fires once per port2_bit7 move with strobe steady high;
  // the sample on which the strobe first goes high never counts as a read,
  // which keeps the write patterns from doubling as reads
  wire rd_fire = prog_en & st_hi & toggle;

  // Signature stays up for as long as the strobe is high
  wire sig_lvl = prog_en & stb_now & hit_sig;

  // ==========================================================
  // Mode decode
  // ==========================================================
  // Strobe level separates the read family from the write pattern that
  // shares its pins; anything else falls back to the plain pattern.
  // The mode is for observation only and changes no stored state.
  always_comb
  begin
    op = FPD_OP_NONE;
    if (prog_en && stb_now && hit_rd_lower)
      op = FPD_OP_RD_LOWER;
    else if (prog_en && stb_now && hit_rd_upper)
      op = FPD_OP_RD_UPPER;
    else if (prog_en)
    begin
      unique case (sel)
        SEL_WR_LOWER: op = FPD_OP_WR_LOWER;
        SEL_WR_UPPER: op = FPD_OP_WR_UPPER;
        SEL_LOCK1:    op = FPD_OP_LOCK1;
        SEL_LOCK2:    op = FPD_OP_LOCK2;
        SEL_LOCK3:    op = FPD_OP_LOCK3;
        SEL_ERASE:    op = FPD_OP_ERASE;
        SEL_SIG:      op = FPD_OP_SIG;
        default:      op = FPD_OP_NONE;
      endcase
    end
  end

  // ==========================================================
  // Command pulses
  // ==========================================================
  // Packed in the field order of the command carrier; all but the
  // signature are single-cycle pulses, the signature is a level
  assign nxt_cmd = {wr_fire & hit_wr_lower,
                    wr_fire & hit_wr_upper,
                    wr_fire & hit_erase,
                    rd_fire & hit_rd_lower,
                    rd_fire & hit_rd_upper,
                    sig_lvl};

  // ==========================================================
  // Lock bits
  // ==========================================================
  // Each lock bit is set by its own pattern and never cleared by another;
  // mass erase and reset are the only ways back to the reset value
  wire set_lock1 = wr_fire & hit_lock1;
  wire set_lock2 = wr_fire & hit_lock2;
  wire set_lock3 = wr_fire & hit_lock3;
  wire clr_locks = wr_fire & hit_erase;

  // Next lock state; unmatched patterns keep the present value
  always_comb
  begin
    nxt_lock = lock_bits;
    if (set_lock1)
      nxt_lock[LOCK1_POS] = 1'h1;
    if (set_lock2)
      nxt_lock[LOCK2_POS] = 1'h1;
    if (set_lock3)
      nxt_lock[LOCK3_POS] = 1'h1;
    if (clr_locks)
      nxt_lock = LOCK_RST;
  end

  // ==========================================================
  // Registers
  // ==========================================================
  // Pin history for edge and toggle detection; cleared to the idle
  // programmer levels so no false strobe rise follows reset
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      pins_ff <= '0;
    else
      pins_ff <= pins;
  end

  // Command outputs, one cycle each except the signature level
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      cmd <= '0;
    else
      cmd <= nxt_cmd;
  end

  // Sticky lock bits
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      lock_bits <= LOCK_RST;
    else
      lock_bits <= nxt_lock;
  end

  // Decoded mode, registered so the output comes from a flip-flop
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      mode <= FPD_OP_NONE;
    else
      mode <= op;
  end

endmodule : fpd_decode

/* tb/fpd_prog_model.sv */
// Programmer model driving the programming pins
`timescale 1ns/1ps
module fpd_prog_model
  import fpd_pkg::*;
(
  input  wire logic mclk, // Device clock, above the write minimum
  output fpd_pins_s pins  // Programming pins
);
  // Pins idle until the first request
  initial pins = '0;
  // Strobe low for the whole cycle with select set, then raised
  task automatic pulse(input logic [4:0] sel, input logic gate);
    @(posedge mclk);
    pins <= '{gate, 1'h0, 1'h0, 1'h1, sel[4], sel[3], sel[2], sel[1], sel[0]};
    @(posedge mclk);
    pins.addr_latch_program_strobe <= 1'h1;
  endtask : pulse
  // Strobe held high with the read pattern, then port2_bit7 toggled n times
  task automatic read_toggle(input logic upper, input int n);
    @(posedge mclk);
    pins <= '{1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, upper};
    @(posedge mclk);
    repeat (n)
    begin
      @(posedge mclk);
      pins.port2_bit7 <= ~pins.port2_bit7;
    end
  endtask : read_toggle
endmodule : fpd_prog_model

/* tb/fpd_decode_props.sv */
// Checker for the programming mode decoder
`timescale 1ns/1ps
module fpd_decode_props
  import fpd_pkg::*;
(
  input wire logic       mclk,      // Clock
  input wire logic       rst,       // Reset
  input wire fpd_pins_s  pins,      // Pins
  input wire fpd_cmd_s   cmd,       // Pulses
  input wire logic [2:0] lock_bits, // Locks
  input wire fpd_op_e    mode       // Mode
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Gate, select and strobe
  wire       g   = pins.rst_pin & ~pins.program_store_enable_n & pins.external_access_vpp;
  wire [4:0] sel = {pins.port2_bit6, pins.port2_bit7, pins.port3_bit6, pins.port3_bit7,
                    pins.port2_bit5};
  wire       stb = pins.addr_latch_program_strobe;
  wire       rd_lo = (sel & SEL_RD_MASK) == SEL_RD_LOWER;
  wire       rd_up = (sel & SEL_RD_MASK) == SEL_RD_UPPER;
  function automatic logic hit(input logic [4:0] s);
    return g && sel == s;
  endfunction : hit
  property p_wrl; $rose(stb) && hit(SEL_WR_LOWER) |=> cmd.wr_lower; endproperty
  property p_wru; $rose(stb) && hit(SEL_WR_UPPER) |=> cmd.wr_upper; endproperty
  property p_ers; $rose(stb) && hit(SEL_ERASE) |=> cmd.mass_erase; endproperty
  property p_lk1; $rose(stb) && hit(SEL_LOCK1) |=> lock_bits[0]; endproperty
  property p_lk2; $rose(stb) && hit(SEL_LOCK2) |=> lock_bits[1]; endproperty
  property p_lk3; $rose(stb) && hit(SEL_LOCK3) |=> lock_bits[2]; endproperty
  property p_sig; stb && hit(SEL_SIG) |=> cmd.rd_sig; endproperty
  property p_gate; !g |=> cmd == 6'h00; endproperty
  property p_keep; !($rose(stb) && g) |=> $stable(lock_bits); endproperty
  property p_rdl;
    !$past(rst) && g && stb && $past(stb) && rd_lo && $changed(pins.port2_bit7)
      |=> cmd.rd_lower;
  endproperty
  property p_rdu;
    !$past(rst) && g && stb && $past(stb) && rd_up && $changed(pins.port2_bit7)
      |=> cmd.rd_upper;
  endproperty
  property p_mode; !stb && hit(SEL_ERASE) |=> mode == FPD_OP_ERASE; endproperty
  a_wrl: assert property (p_wrl) else $error("lower write missing");
  a_wru: assert property (p_wru) else $error("upper write missing");
  a_ers: assert property (p_ers) else $error("erase missing");
  a_lk1: assert property (p_lk1) else $error("lock one missing");
  a_lk2: assert property (p_lk2) else $error("lock two missing");
  a_lk3: assert property (p_lk3) else $error("lock three missing");
  a_sig: assert property (p_sig) else $error("signature missing");
  a_gate: assert property (p_gate) else $error("pulse while gated");
  a_keep: assert property (p_keep) else $error("locks changed");
  a_rdl: assert property (p_rdl) else $error("lower read missing");
  a_rdu: assert property (p_rdu) else $error("upper read missing");
  a_mode: assert property (p_mode) else $error("erase mode missing");
  c_rd: cover property (cmd.rd_upper);
  c_wr: cover property (cmd.wr_lower);
  c_er: cover property (cmd.mass_erase);
  c_lk: cover property (lock_bits == 3'h7);
endmodule : fpd_decode_props
bind fpd_decode fpd_decode_props u_fpd_decode_props (.mclk(mclk), .rst(rst), .pins(pins),
  .cmd(cmd), .lock_bits(lock_bits), .mode(mode));

/* tb/tb_top.sv */
// Self-checking bench for the programming mode decoder
`timescale 1ns/1ps
module tb_top
  import fpd_pkg::*;
();
  logic        mclk;
  logic        rst = 1'h1;
  fpd_pins_s   pins;
  fpd_cmd_s    cmd;
  logic [2:0]  lock_bits;
  fpd_op_e     mode;
  logic [4:0]  exp_q[$];
  logic [2:0]  exp_lk = 3'h0;
  logic [31:0] rnd = 32'h7;
  int          miscompares = 0;
  int          checks_done = 0;
  wire  [4:0]  pulse_seen = {cmd.wr_lower, cmd.wr_upper, cmd.mass_erase, cmd.rd_lower,
                             cmd.rd_upper};
  localparam logic [4:0] DIRS [6] = '{SEL_ERASE, SEL_LOCK1, SEL_LOCK2, SEL_LOCK3,
                                      SEL_WR_LOWER, SEL_WR_UPPER};
  fpd_decode u_fpd_decode (.mclk(mclk), .rst(rst), .pins(pins), .cmd(cmd),
                           .lock_bits(lock_bits), .mode(mode));
  fpd_prog_model u_fpd_prog_model (.mclk(mclk), .pins(pins));
  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction : xs
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // Note the expected pulse and lock state, then strobe
  task automatic send(input logic [4:0] sel, input logic gate);
    if (gate && sel == SEL_WR_LOWER) exp_q.push_back(5'h10);
    if (gate && sel == SEL_WR_UPPER) exp_q.push_back(5'h08);
    if (gate && sel == SEL_ERASE) exp_q.push_back(5'h04);
    if (gate && sel == SEL_ERASE) exp_lk = 3'h0;
    exp_lk |= {gate && sel == SEL_LOCK3, gate && sel == SEL_LOCK2, gate && sel == SEL_LOCK1};
    u_fpd_prog_model.pulse(sel, gate);
  endtask : send
  // ==========================================================
  // Clock and watchdog
  initial
  begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  initial
  begin
    #5000;
    miscompares++;
    final_report();
  end
  // Write and read pulses against the oldest note
  always @(negedge mclk)
    if (pulse_seen !== 5'h00)
      check(8'(pulse_seen), 8'(exp_q.size() ? exp_q.pop_front() : 5'h00));
  // ==========================================================
  // Directed then random sequences
  initial
  begin
    repeat (6) @(posedge mclk);
    rst <= 1'h0;
    foreach (DIRS[i]) send(DIRS[i], 1'h1);
    send(SEL_SIG, 1'h1);
    repeat (2) @(posedge mclk);
    #1 check(8'(cmd.rd_sig), 8'h01);
    check(8'(lock_bits), 8'(exp_lk));
    repeat (4) exp_q.push_back(5'h02);
    u_fpd_prog_model.read_toggle(1'h0, 4);
    repeat (2) exp_q.push_back(5'h01);
    u_fpd_prog_model.read_toggle(1'h1, 2);
    @(posedge mclk);
    #1 check(8'(mode), 8'(FPD_OP_RD_UPPER));
    $display("directed test done");
    repeat (60)
    begin
      rnd = xs(rnd);
      send(rnd[4:0], rnd[5] | rnd[6]);
    end
    repeat (4) @(posedge mclk);
    #1 check(8'(exp_q.size()), 8'h00);
    check(8'(lock_bits), 8'(exp_lk));
    $display("random test done");
    final_report();
  end
endmodule : tb_top
